// ==== rtl/prbs_channel.sv ====
/*
 One transceiver channel's stimulus and checker: raw PRBS-31 generator on transmit,
 self-synchronising PRBS-31 checker on receive, with optional bit inversion as the
 only format adaptation.
 Assumes transmit and receive words are in the clk_sys domain.
*/
`timescale 1ns/1ps
module prbs_channel
    import prbs_link_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic         invert_fmt,
    input  wire logic         tx_ready,
    output logic [W-1:0]      tx_data,
    input  wire logic [W-1:0] rx_data,
    input  wire logic         rx_valid,
    output logic              match
);
    logic [30:0]  gen_reg;
    logic [30:0]  gen_next;
    logic [30:0]  chk_reg;
    logic [30:0]  chk_next;
    logic [W-1:0] gen_word;
    logic [W-1:0] err_word;
    logic [W-1:0] rx_norm;
    logic [W-1:0] tx_data_next;

    // Serial LFSR unrolled over one word, first bit in LSB
    always_comb begin
        gen_next = gen_reg;
        gen_word = '0;
        chk_next = chk_reg;
        err_word = '0;
        for (int i = 0; i < W; i++) begin
            gen_word[i] = gen_next[PRBS_TAP_A] ^ gen_next[PRBS_TAP_B];
            gen_next    = {gen_next[29:0], gen_word[i]};
            err_word[i] = rx_norm[i] ^ chk_next[PRBS_TAP_A] ^ chk_next[PRBS_TAP_B];
            chk_next    = {chk_next[29:0], rx_norm[i]};
        end
    end

    // Receive and transmit adaptation: polarity only, nothing protocol-like
    assign rx_norm      = invert_fmt ? ~rx_data : rx_data;
    assign tx_data_next = invert_fmt ? ~gen_word : gen_word;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            gen_reg <= PRBS_SEED;
            tx_data <= '0;
        end else if (tx_ready) begin
            gen_reg <= gen_next;
            tx_data <= tx_data_next;
        end
    end

    // Checker seeds itself from received bits, so it locks once 31 clean bits are in (one word when W is 31 or more)
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            chk_reg <= '0;
            match   <= 1'b0;
        end else if (rx_valid) begin
            chk_reg <= chk_next;
            match   <= (err_word == '0) && (chk_reg != '0);
        end
    end
endmodule

// ==== rtl/prbs_link_pkg.sv ====
/*
 Constants for the PRBS link status monitor: pattern polynomial, link thresholds,
 bring-up timing and tie-off values.
 Assumes one system clock at 200 MHz; channel data already in that domain's timing.
*/
package prbs_link_pkg;

    localparam int         PRBS_WIDTH      = 31;
    localparam logic [30:0] PRBS_SEED      = 31'h7FFF_FFFF;
    localparam int         PRBS_TAP_A      = 30;
    localparam int         PRBS_TAP_B      = 27;

    localparam int         MATCH_RUN_UP    = 128;
    localparam int         MISMATCH_LIMIT  = 4;
    localparam int         WINDOW_LEN      = 256;

    localparam int         CLK_PERIOD_PS   = 5000;
    localparam int         INIT_WAIT_NS    = 130000;
    localparam int         INIT_WAIT_CYC   = (INIT_WAIT_NS * 1000) / CLK_PERIOD_PS;
    localparam int         RESET_PULSE_CYC = 16;

    localparam logic [2:0] TIE_LOOPBACK    = 3'h0;
    localparam logic [3:0] TIE_PRBS_SEL    = 4'h0;
    localparam logic       TIE_POLARITY    = 1'b0;

endpackage

// ==== rtl/prbs_link_status_monitor.sv ====
/*
 PRBS link status monitor: per-channel generators and checkers, match-all merge,
 link status machine, sticky link-down flag and bring-up init machine.
 Assumes all channel user interfaces are synchronous to clk_sys; external resets
 and clear inputs are debounced off chip.
*/
`timescale 1ns/1ps
module prbs_link_status_monitor
    import prbs_link_pkg::*;
#(
    parameter int NCH        = 4,
    parameter int W          = 32,
    parameter int RUN_UP     = MATCH_RUN_UP,
    parameter int MISS_LIMIT = MISMATCH_LIMIT,
    parameter int WIN_LEN    = WINDOW_LEN,
    parameter int INIT_WAIT  = INIT_WAIT_CYC
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             system_reset_request_in,
    input  wire logic             link_down_clear_in,
    input  wire logic             invert_fmt,
    input  wire logic             reset_done_in,
    input  wire logic [NCH-1:0]   tx_ready,
    input  wire logic [NCH*W-1:0] rx_data,
    input  wire logic [NCH-1:0]   rx_valid,
    output logic [NCH*W-1:0]      tx_data,
    output logic                  link_status_out,
    output logic                  link_down_latched_out,
    output logic                  reset_all_out,
    output logic                  reset_rx_out,
    output logic [2:0]            loopback_out,
    output logic [3:0]            prbs_sel_out,
    output logic                  polarity_out
);
    typedef enum logic [1:0] {
        LINK_DOWN = 2'b01,
        LINK_UP   = 2'b10
    } link_state_e;

    typedef enum logic [3:0] {
        INIT_IDLE  = 4'b0001,
        INIT_RESET = 4'b0010,
        INIT_SETTLE = 4'b0100,
        INIT_DONE  = 4'b1000
    } init_state_e;

    logic [NCH-1:0] match_raw;
    logic [NCH-1:0] match_meta_reg;
    logic [NCH-1:0] match_sync_reg;
    logic           match_all;

    link_state_e    link_reg;
    link_state_e    link_next;
    logic [15:0]    run_reg;
    logic [15:0]    win_reg;
    logic [15:0]    miss_reg;
    logic           win_end;
    logic           miss_hit;
    logic           run_hit;

    logic           clr_meta_reg;
    logic           clr_sync_reg;
    logic           req_meta_reg;
    logic           req_sync_reg;
    logic           req_prev_reg;
    logic           req_fall;

    init_state_e    init_reg;
    init_state_e    init_next;
    logic [31:0]    wait_reg;
    logic           wait_hit;
    logic           pulse_hit;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            prbs_channel #(.W(W)) u_ch (
                .clk_sys    (clk_sys),
                .reset_n    (reset_n),
                .invert_fmt (invert_fmt),
                .tx_ready   (tx_ready[g]),
                .tx_data    (tx_data[g*W +: W]),
                .rx_data    (rx_data[g*W +: W]),
                .rx_valid   (rx_valid[g]),
                .match      (match_raw[g])
            );
        end
    endgenerate

    // Per-channel matches synchronized before merging; costs two cycles latency
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            match_meta_reg <= '0;
            match_sync_reg <= '0;
        end else begin
            match_meta_reg <= match_raw;
            match_sync_reg <= match_meta_reg;
        end
    end

    assign match_all = &match_sync_reg;

    // Link machine: run counter to go up, mismatches counted per window to go down
    assign run_hit  = match_all && (run_reg == 16'(RUN_UP - 1));
    assign win_end  = (win_reg == 16'(WIN_LEN - 1));
    assign miss_hit = !match_all && (miss_reg == 16'(MISS_LIMIT - 1));

    always_comb begin
        link_next = link_reg;
        unique case (link_reg)
            LINK_DOWN: if (run_hit) link_next = LINK_UP;
            LINK_UP:   if (miss_hit) link_next = LINK_DOWN;
            default:   link_next = LINK_DOWN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n || req_fall) begin
            link_reg <= LINK_DOWN;
            run_reg  <= '0;
            win_reg  <= '0;
            miss_reg <= '0;
        end else begin
            link_reg <= link_next;
            run_reg  <= match_all ? run_reg + 16'h0001 : 16'h0000;
            win_reg  <= win_end ? 16'h0000 : win_reg + 16'h0001;
            if (win_end || link_reg == LINK_DOWN)
                miss_reg <= '0;
            else if (!match_all)
                miss_reg <= miss_reg + 16'h0001;
        end
    end

    // Clear and reset request are asynchronous; two-stage synchronizers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            clr_meta_reg <= 1'b0;
            clr_sync_reg <= 1'b0;
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
            req_prev_reg <= 1'b0;
        end else begin
            clr_meta_reg <= link_down_clear_in;
            clr_sync_reg <= clr_meta_reg;
            req_meta_reg <= system_reset_request_in;
            req_sync_reg <= req_meta_reg;
            req_prev_reg <= req_sync_reg;
        end
    end

    assign req_fall = req_prev_reg && !req_sync_reg;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            link_status_out       <= 1'b0;
            link_down_latched_out <= 1'b1;
        end else begin
            link_status_out <= (link_next == LINK_UP) && !req_fall;
            // Set wins over clear so a drop during clear is never missed
            if (link_status_out && !((link_next == LINK_UP) && !req_fall))
                link_down_latched_out <= 1'b1;
            else if (clr_sync_reg)
                link_down_latched_out <= 1'b0;
        end
    end

    // Init machine: wait for reset done, wait for link, pulse rx reset on timeout
    assign wait_hit  = (wait_reg == 32'(INIT_WAIT - 1));
    assign pulse_hit = (wait_reg == 32'(RESET_PULSE_CYC - 1));

    always_comb begin
        init_next = init_reg;
        unique case (init_reg)
            INIT_IDLE:  if (reset_done_in) init_next = INIT_SETTLE;
            INIT_RESET: if (pulse_hit) init_next = INIT_IDLE;
            INIT_SETTLE: begin
                if (link_status_out)
                    init_next = INIT_DONE;
                else if (wait_hit)
                    init_next = INIT_RESET;
            end
            INIT_DONE:  if (!link_status_out) init_next = INIT_SETTLE;
            default:    init_next = INIT_IDLE;
        endcase
        if (req_fall)
            init_next = INIT_IDLE;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            init_reg      <= INIT_IDLE;
            wait_reg      <= '0;
            reset_all_out <= 1'b0;
            reset_rx_out  <= 1'b0;
        end else begin
            init_reg      <= init_next;
            wait_reg      <= (init_next != init_reg) ? 32'h0000_0000 : wait_reg + 32'h0000_0001;
            reset_all_out <= req_fall;
            reset_rx_out  <= (init_next == INIT_RESET);
        end
    end

    // Unused core controls held at configuration constants
    always_ff @(posedge clk_sys) begin
        loopback_out <= TIE_LOOPBACK;
        prbs_sel_out <= TIE_PRBS_SEL;
        polarity_out <= TIE_POLARITY;
    end
endmodule

// ==== tb/prbs_link_chk.sv ====
/*
 Assertion checker for the PRBS link status monitor outputs.
 Assumes binding to the top module; inputs move at the falling clock edge.
*/
`timescale 1ns/1ps
module prbs_link_chk #(
    parameter int RUN_UP = 128
) (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       system_reset_request_in,
    input wire logic       link_down_clear_in,
    input wire logic       link_status_out,
    input wire logic       link_down_latched_out,
    input wire logic       reset_all_out,
    input wire logic       reset_rx_out,
    input wire logic [2:0] loopback_out,
    input wire logic [3:0] prbs_sel_out,
    input wire logic       polarity_out
);
    logic [9:0] up_cnt_reg;
    logic [5:0] rx_cnt_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Saturates so a long run never wraps back below the threshold
    // Link machine restarts on the edge that launches the pulse, so that edge counts
    always_ff @(posedge clk_sys) begin
        up_cnt_reg <= !reset_n ? 10'h000
                    : reset_all_out ? 10'h001
                    : up_cnt_reg + {9'h000, ~&up_cnt_reg};
        rx_cnt_reg <= reset_rx_out ? rx_cnt_reg + 6'h01 : 6'h00;
    end
    property p_ties; loopback_out == 3'h0 && prbs_sel_out == 4'h0 && !polarity_out; endproperty
    a_ties: assert property (p_ties) else $error("tie-off output not constant");
    property p_set; $fell(link_status_out) |-> link_down_latched_out; endproperty
    a_set: assert property (p_set) else $error("flag not set on link drop");
    property p_clr;
        $fell(link_down_latched_out) |-> $past(link_down_clear_in, 2) || $past(link_down_clear_in, 3);
    endproperty
    a_clr: assert property (p_clr) else $error("flag cleared without clear input");
    property p_pulse; reset_all_out |=> !reset_all_out; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse longer than one cycle");
    property p_cause; $fell(system_reset_request_in) |-> ##[1:5] reset_all_out; endproperty
    a_cause: assert property (p_cause) else $error("no reset pulse after request fell");
    property p_down; reset_all_out |-> ##[0:3] !link_status_out; endproperty
    a_down: assert property (p_down) else $error("link kept up across full reset");
    property p_run; $rose(link_status_out) |-> up_cnt_reg >= RUN_UP; endproperty
    a_run: assert property (p_run) else $error("link up before match run");
    property p_rxlen; $fell(reset_rx_out) |-> rx_cnt_reg == 6'h10; endproperty
    a_rxlen: assert property (p_rxlen) else $error("receiver reset length wrong");
endmodule

bind prbs_link_status_monitor prbs_link_chk #(.RUN_UP(RUN_UP)) chk_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .system_reset_request_in(system_reset_request_in),
    .link_down_clear_in(link_down_clear_in), .link_status_out(link_status_out),
    .link_down_latched_out(link_down_latched_out), .reset_all_out(reset_all_out),
    .reset_rx_out(reset_rx_out), .loopback_out(loopback_out), .prbs_sel_out(prbs_sel_out),
    .polarity_out(polarity_out));

// ==== tb/prbs_link_status_monitor_tb.sv ====
/*
 Self-checking testbench for the PRBS link status monitor, two channels in loopback.
 Assumes the loopback partner model and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module prbs_link_status_monitor_tb;
    localparam int NCH = 2;
    localparam int W   = 16;
    logic             clk_sys, reset_n, req, clr, inv, done, run;
    logic             link, latched, rst_all, rst_rx;
    logic [NCH-1:0]   err_ch, rx_valid, tx_ready;
    logic [NCH*W-1:0] tx_data, rx_data;
    int               fail_count, checks;

    // Short counts keep the run brief; expectations use the same values
    prbs_link_status_monitor #(.NCH(NCH), .W(W), .RUN_UP(16), .MISS_LIMIT(4), .WIN_LEN(32),
        .INIT_WAIT(40)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .system_reset_request_in(req),
        .link_down_clear_in(clr), .invert_fmt(inv), .reset_done_in(done),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
        .link_status_out(link), .link_down_latched_out(latched), .reset_all_out(rst_all),
        .reset_rx_out(rst_rx), .loopback_out(), .prbs_sel_out(), .polarity_out());
    prbs_loop_partner #(.NCH(NCH), .W(W)) partner_u (
        .clk_sys(clk_sys), .run(run), .err_ch(err_ch), .tx_data(tx_data),
        .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));

    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wait_link(input logic v, input int n);
        int i;
        for (i = 0; i < n && link !== v; i++) @(negedge clk_sys);
        if (i == n) begin
            fail_count++;
            wrap_up();
        end
    endtask

    task automatic t_init();
        int n;
        n = 0;
        done = 1'h1;
        for (int i = 0; i < 100 && rst_rx !== 1'h1; i++) @(negedge clk_sys);
        if (rst_rx !== 1'h1) begin
            fail_count++;
            wrap_up();
        end
        done = 1'h0;
        while (rst_rx === 1'h1 && n < 40) begin
            n++;
            @(negedge clk_sys);
        end
        `CHK("reset_rx cycles", 16, n)
    endtask

    task automatic t_bringup();
        `CHK("flag after reset", 1'h1, latched)
        run = 1'h1;
        idle(12);
        `CHK("link before run", 1'h0, link)
        wait_link(1'h1, 200);
        `CHK("flag after recovery", 1'h1, latched)
    endtask

    task automatic t_clear();
        clr = 1'h1;
        idle(4);
        clr = 1'h0;
        `CHK("flag cleared", 1'h0, latched)
    endtask

    task automatic t_isolated();
        err_ch = 2'h1;
        idle(1);
        err_ch = 2'h0;
        idle(60);
        `CHK("link after one error", 1'h1, link)
        `CHK("flag after one error", 1'h0, latched)
    endtask

    task automatic t_fail();
        // Only lane 1 fails, so the drop proves lane 1 is in the merge
        err_ch = 2'h2;
        wait_link(1'h0, 100);
        `CHK("flag after drop", 1'h1, latched)
        err_ch = 2'h0;
        inv = 1'h1;
        wait_link(1'h1, 200);
        `CHK("flag kept set", 1'h1, latched)
    endtask

    task automatic t_reset_req();
        int k;
        k = 0;
        req = 1'h1;
        idle(6);
        req = 1'h0;
        // Two sync stages, edge detect, then the registered pulse
        while (rst_all !== 1'h1 && k < 8) begin
            k++;
            @(negedge clk_sys);
        end
        `CHK("reset_all pulse", 1'h1, rst_all)
        `CHK("reset_all delay", 3, k)
        idle(1);
        `CHK("reset_all width", 1'h0, rst_all)
        wait_link(1'h0, 10);
        wait_link(1'h1, 200);
    endtask

    initial begin
        fail_count = 0;
        checks = 0;
        {req, clr, inv, done, run, reset_n} = 6'h00;
        err_ch = 2'h0;
        idle(4);
        reset_n = 1'h1;
        idle(1);
        t_init();
        t_bringup();
        t_clear();
        t_isolated();
        t_fail();
        t_reset_req();
        wrap_up();
    end
endmodule

// ==== tb/prbs_loop_partner.sv ====
/*
 Loopback partner: returns each transmit word as the receive word one cycle later,
 with bit 0 of a channel flipped on command. Assumes tx_data is registered.
*/
`timescale 1ns/1ps
module prbs_loop_partner #(
    parameter int NCH = 2,
    parameter int W   = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             run,
    input  wire logic [NCH-1:0]   err_ch,
    input  wire logic [NCH*W-1:0] tx_data,
    output logic [NCH*W-1:0]      rx_data,
    output logic [NCH-1:0]        rx_valid,
    output logic [NCH-1:0]        tx_ready
);
    logic [NCH*W-1:0] flip;
    initial rx_data = '0;
    always_comb begin
        flip = '0;
        for (int g = 0; g < NCH; g++) flip[g*W] = err_ch[g];
    end
    // A stopped lane shows a changing pattern rather than its last word
    always @(posedge clk_sys) begin
        rx_data <= run ? tx_data ^ flip : ~rx_data;
    end
    assign rx_valid = {NCH{run}};
    assign tx_ready = {NCH{run}};
endmodule
